// ### common/tei_pkg.sv
// Constants shared by the external input conditioning block and its helpers.
// Assumes a 32-bit AXI4-Lite register bus and pins that idle high.
package tei_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_TMR0 = 4'h8;
  localparam logic [3:0] OFS_TMR1 = 4'hC;
  localparam int unsigned OFS_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // Control register fields
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CTRL_EDGE0 = 0;
  localparam int unsigned CTRL_EDGE1 = 1;
  localparam int unsigned CTRL_TIMER_ZERO_GATE_SELECT = 2;
  localparam int unsigned CTRL_TIMER_ONE_GATE_SELECT = 3;
  localparam int unsigned CTRL_RUN0 = 4;
  localparam int unsigned CTRL_RUN1 = 5;
  localparam int unsigned CTRL_CNT0 = 6;
  localparam int unsigned CTRL_CNT1 = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status register fields
  localparam int unsigned STAT_FLAG0 = 0;
  localparam int unsigned STAT_FLAG1 = 1;
  localparam int unsigned STAT_LVL0 = 2;
  localparam int unsigned STAT_LVL1 = 3;

  // Pin vector layout inside the synchroniser
  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_IRQ0 = 0;
  localparam int unsigned PIN_IRQ1 = 1;
  localparam int unsigned PIN_CNT0 = 2;
  localparam int unsigned PIN_CNT1 = 3;

  // Timer width and reset value
  localparam int unsigned TMR_W = 16;
  localparam logic [15:0] TMR_RST = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_STATUS,
    SEL_TMR0,
    SEL_TMR1,
    SEL_NONE
  } tei_sel_type;
endpackage

// ### rtl/tei_pin_sync.sv
// Two-stage synchroniser plus falling-edge detector for a vector of pins.
// Assumes pins idle high; the first stage feeds only the second.
`timescale 1ns/1ps
module tei_pin_sync #(
  parameter int unsigned WIDTH = tei_pkg::PIN_N
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } tei_sync_state_type;

  tei_sync_state_type st_r;
  tei_sync_state_type st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("tei_pin_sync: WIDTH must be at least 1");
  end

  // Shift the pins through; reset to idle high so release makes no edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins;
    st_nxt.stable = st_r.meta;
    st_nxt.prev = st_r.stable;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edge taken between the two settled stages, never from the first
  assign level = st_r.stable;
  assign fall = st_r.prev & ~st_r.stable;

  for (genvar i = 0; i < WIDTH; i++) begin : g_chk
    sequence s_pin_fell;
      $fell(pins[i]);
    endsequence
    sequence s_edge_out;
      ##2 fall[i];
    endsequence
    a_fall_two_late: assert property (@(posedge core_clk) disable iff (srst)
      s_pin_fell |-> s_edge_out) else $error("falling pin not flagged two cycles on");
    a_fall_one_pulse: assert property (@(posedge core_clk) disable iff (srst)
      fall[i] |=> !fall[i]) else $error("edge pulse longer than one cycle");
  end
endmodule // tei_pin_sync

// ### rtl/tei_timer.sv
// One up-counting timer with load, run control and counter mode.
// Assumes the count edge is a one-cycle pulse already synchronised.
`timescale 1ns/1ps
module tei_timer #(
  parameter int unsigned WIDTH = tei_pkg::TMR_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic count_mode,
  input wire logic count_edge,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tei_timer_state_type;

  tei_timer_state_type st_r;
  tei_timer_state_type st_nxt;

  if (WIDTH < 1 || WIDTH > tei_pkg::TMR_W) begin : g_bad_width
    $error("tei_timer: WIDTH must lie between 1 and 16");
  end

  // Load has priority so software sees the value it wrote
  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.count = load_value;
    end else if (run && (count_mode ? count_edge : 1'b1)) begin
      st_nxt.count = WIDTH'(st_r.count + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= WIDTH'(tei_pkg::TMR_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;

  a_load_value: assert property (@(posedge core_clk) disable iff (srst)
    load |=> count == $past(load_value)) else $error("timer load not taken");
endmodule // tei_timer

// ### rtl/tei_top.sv
// External interrupt and timer input conditioning with an AXI4-Lite slave.
// Assumes pins asynchronous inputs that idle high and one AXI master.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tei_top #(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ext_irq_pin_ch0,
  input wire logic ext_irq_pin_ch1,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_flag_ch0,
  output logic irq_flag_ch1,
  output logic [15:0] timer_zero_count,
  output logic [15:0] timer_one_count
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic [1:0] flag;
  } tei_top_state_type;

  tei_top_state_type st_r;
  tei_top_state_type st_nxt;

  logic [tei_pkg::PIN_N-1:0] pin_level;
  logic [tei_pkg::PIN_N-1:0] pin_fall;
  logic do_write;
  tei_pkg::tei_sel_type wr_sel;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic run0;
  logic run1;
  logic load0;
  logic load1;
  logic [31:0] tmr0_merged;
  logic [31:0] tmr1_merged;

  if (ADDR_W < tei_pkg::OFS_W || ADDR_W > 32) begin : g_bad_addr
    $error("tei_top: ADDR_W must lie between 4 and 32");
  end

  // Word decode shared by the read and write paths; upper bits must be zero
  function automatic tei_pkg::tei_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [3:0] low;
    low = addr[3:0];
    decode = tei_pkg::SEL_NONE;
    if ((addr >> tei_pkg::OFS_W) == '0) begin
      unique case (low)
        tei_pkg::OFS_CTRL: decode = tei_pkg::SEL_CTRL;
        tei_pkg::OFS_STATUS: decode = tei_pkg::SEL_STATUS;
        tei_pkg::OFS_TMR0: decode = tei_pkg::SEL_TMR0;
        tei_pkg::OFS_TMR1: decode = tei_pkg::SEL_TMR1;
        default: decode = tei_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge used by the two timer registers only
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge = res;
  endfunction

  // Pins pass the synchroniser before any flag or timer looks at them
  tei_pin_sync #(
    .WIDTH(tei_pkg::PIN_N)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pins({timer_one_count_pin, timer_zero_count_pin, ext_irq_pin_ch1, ext_irq_pin_ch0}),
    .level(pin_level),
    .fall(pin_fall)
  );

  // A write fires once both halves are held and no response is pending
  assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
  assign wr_sel = decode(st_r.aw_addr);

  // Flag sources: edge pulse or low level, chosen per channel
  assign flag_set[0] = st_r.ctrl[tei_pkg::CTRL_EDGE0] ? pin_fall[tei_pkg::PIN_IRQ0]
                                                      : !pin_level[tei_pkg::PIN_IRQ0];
  assign flag_set[1] = st_r.ctrl[tei_pkg::CTRL_EDGE1] ? pin_fall[tei_pkg::PIN_IRQ1]
                                                      : !pin_level[tei_pkg::PIN_IRQ1];
  // Write one to clear; a set in the same cycle still wins
  assign flag_clr[0] = do_write && wr_sel == tei_pkg::SEL_STATUS && st_r.w_strb[0]
                       && st_r.w_data[tei_pkg::STAT_FLAG0];
  assign flag_clr[1] = do_write && wr_sel == tei_pkg::SEL_STATUS && st_r.w_strb[0]
                       && st_r.w_data[tei_pkg::STAT_FLAG1];

  // Gate select makes the interrupt pin a second run condition
  assign run0 = st_r.ctrl[tei_pkg::CTRL_RUN0]
                && (!st_r.ctrl[tei_pkg::CTRL_TIMER_ZERO_GATE_SELECT] || pin_level[tei_pkg::PIN_IRQ0]);
  assign run1 = st_r.ctrl[tei_pkg::CTRL_RUN1]
                && (!st_r.ctrl[tei_pkg::CTRL_TIMER_ONE_GATE_SELECT] || pin_level[tei_pkg::PIN_IRQ1]);

  // Timer loads from the bus
  assign load0 = do_write && wr_sel == tei_pkg::SEL_TMR0;
  assign load1 = do_write && wr_sel == tei_pkg::SEL_TMR1;
  assign tmr0_merged = merge({16'h0000, timer_zero_count}, st_r.w_data, st_r.w_strb);
  assign tmr1_merged = merge({16'h0000, timer_one_count}, st_r.w_data, st_r.w_strb);

  tei_timer #(
    .WIDTH(tei_pkg::TMR_W)
  ) u_timer0 (
    .core_clk(core_clk),
    .srst(srst),
    .run(run0),
    .count_mode(st_r.ctrl[tei_pkg::CTRL_CNT0]),
    .count_edge(pin_fall[tei_pkg::PIN_CNT0]),
    .load(load0),
    .load_value(tmr0_merged[15:0]),
    .count(timer_zero_count)
  );

  tei_timer #(
    .WIDTH(tei_pkg::TMR_W)
  ) u_timer1 (
    .core_clk(core_clk),
    .srst(srst),
    .run(run1),
    .count_mode(st_r.ctrl[tei_pkg::CTRL_CNT1]),
    .count_edge(pin_fall[tei_pkg::PIN_CNT1]),
    .load(load1),
    .load_value(tmr1_merged[15:0]),
    .count(timer_one_count)
  );

  // Bus slave and register state; one write and one read in flight at most
  always_comb begin
    tei_pkg::tei_sel_type rd_sel;
    rd_sel = decode(s_axi_araddr);
    st_nxt = st_r;
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (do_write) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wr_sel == tei_pkg::SEL_NONE) ? tei_pkg::RESP_SLVERR : tei_pkg::RESP_OKAY;
      if (wr_sel == tei_pkg::SEL_CTRL && st_r.w_strb[0]) begin
        st_nxt.ctrl = st_r.w_data[7:0];
      end
    end
    // Flags: set beats clear
    st_nxt.flag = flag_set | (st_r.flag & ~flag_clr);
    // Held halves block a second write until the response is accepted
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = tei_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      unique case (rd_sel)
        tei_pkg::SEL_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
        tei_pkg::SEL_STATUS: st_nxt.rdata = {28'h0000000, pin_level[tei_pkg::PIN_IRQ1],
                                             pin_level[tei_pkg::PIN_IRQ0], st_r.flag};
        tei_pkg::SEL_TMR0: st_nxt.rdata = {16'h0000, timer_zero_count};
        tei_pkg::SEL_TMR1: st_nxt.rdata = {16'h0000, timer_one_count};
        tei_pkg::SEL_NONE: st_nxt.rresp = tei_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.ctrl <= tei_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq_flag_ch0 = st_r.flag[0];
  assign irq_flag_ch1 = st_r.flag[1];

  // Checks on flag setting
  a_edge_flag_ch0: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_EDGE0] && pin_fall[tei_pkg::PIN_IRQ0] |=> irq_flag_ch0)
    else $error("edge on channel 0 did not set its flag");
  a_level_flag_ch0: assert property (@(posedge core_clk) disable iff (srst)
    !st_r.ctrl[tei_pkg::CTRL_EDGE0] && !pin_level[tei_pkg::PIN_IRQ0] |=> irq_flag_ch0)
    else $error("low level on channel 0 did not set its flag");
  a_edge_flag_ch1: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_EDGE1] && pin_fall[tei_pkg::PIN_IRQ1] |=> irq_flag_ch1)
    else $error("edge on channel 1 did not set its flag");
  a_level_flag_ch1: assert property (@(posedge core_clk) disable iff (srst)
    !st_r.ctrl[tei_pkg::CTRL_EDGE1] && !pin_level[tei_pkg::PIN_IRQ1] |=> irq_flag_ch1)
    else $error("low level on channel 1 did not set its flag");
  a_edge_no_spurious: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_EDGE0] && !irq_flag_ch0 && !pin_fall[tei_pkg::PIN_IRQ0]
    |=> !irq_flag_ch0) else $error("channel 0 flag set without an edge");

  // Checks on gating and counting
  a_gate_stops_t0: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_TIMER_ZERO_GATE_SELECT] && !pin_level[tei_pkg::PIN_IRQ0] && !load0
    |=> $stable(timer_zero_count)) else $error("timer 0 ran while its gate was low");
  a_gate_stops_t1: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_TIMER_ONE_GATE_SELECT] && !pin_level[tei_pkg::PIN_IRQ1] && !load1
    |=> $stable(timer_one_count)) else $error("timer 1 ran while its gate was low");
  a_count_step_t0: assert property (@(posedge core_clk) disable iff (srst)
    run0 && st_r.ctrl[tei_pkg::CTRL_CNT0] && !load0
    |=> timer_zero_count == 16'($past(timer_zero_count) + $past(pin_fall[tei_pkg::PIN_CNT0])))
    else $error("timer 0 count step wrong");
  a_count_step_t1: assert property (@(posedge core_clk) disable iff (srst)
    run1 && st_r.ctrl[tei_pkg::CTRL_CNT1] && !load1
    |=> timer_one_count == 16'($past(timer_one_count) + $past(pin_fall[tei_pkg::PIN_CNT1])))
    else $error("timer 1 count step wrong");

  // Bus checks
  a_bresp_holds: assert property (@(posedge core_clk) disable iff (srst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  a_read_answer: assert property (@(posedge core_clk) disable iff (srst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");

  // Clearing must work once the source is quiet, a quiet edge channel must not set its flag, and an open gate must let the timer run
  a_clear_edge_ch0: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_EDGE0] && flag_clr[0] && !pin_fall[tei_pkg::PIN_IRQ0]
    |=> !irq_flag_ch0) else $error("channel 0 flag survived a clear without an edge");
  a_edge_quiet_ch1: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_EDGE1] && !irq_flag_ch1 && !pin_fall[tei_pkg::PIN_IRQ1]
    |=> !irq_flag_ch1) else $error("channel 1 flag set without an edge");
  a_clear_level_ch1: assert property (@(posedge core_clk) disable iff (srst)
    !st_r.ctrl[tei_pkg::CTRL_EDGE1] && pin_level[tei_pkg::PIN_IRQ1] && flag_clr[1]
    |=> !irq_flag_ch1) else $error("channel 1 flag not cleared with its pin high");
  a_gate_runs_t0: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_TIMER_ZERO_GATE_SELECT] && st_r.ctrl[tei_pkg::CTRL_RUN0]
    && pin_level[tei_pkg::PIN_IRQ0] && !st_r.ctrl[tei_pkg::CTRL_CNT0] && !load0
    |=> timer_zero_count == 16'($past(timer_zero_count) + 16'h0001))
    else $error("timer 0 stood still while its gate was high");
  a_gate_runs_t1: assert property (@(posedge core_clk) disable iff (srst)
    st_r.ctrl[tei_pkg::CTRL_TIMER_ONE_GATE_SELECT] && st_r.ctrl[tei_pkg::CTRL_RUN1]
    && pin_level[tei_pkg::PIN_IRQ1] && !st_r.ctrl[tei_pkg::CTRL_CNT1] && !load1
    |=> timer_one_count == 16'($past(timer_one_count) + 16'h0001))
    else $error("timer 1 stood still while its gate was high");
endmodule // tei_top

// ### dv/tei_pin_model.sv
// Behavioural model of the external circuitry driving the four input pins.
// Assumes one core clock; pins are pulled up, so idle and reset level is high.
`timescale 1ns/1ps
module tei_pin_model (
  input wire logic core_clk,
  output logic [3:0] pins
);
  // Pull-ups hold every pin high until the bench commands otherwise
  initial begin
    pins = 4'hF;
  end

  // Drive one pin to a level just after a rising edge
  task automatic set_pin(input int idx, input logic val);
    @(posedge core_clk);
    pins[idx] <= val;
  endtask

  // One low pulse; each level is held long enough for the synchroniser to see it
  task automatic pulse(input int idx, input int low_cyc, input int high_cyc);
    set_pin(idx, 1'b0);
    repeat (low_cyc) @(posedge core_clk);
    pins[idx] <= 1'b1;
    repeat (high_cyc) @(posedge core_clk);
  endtask
endmodule // tei_pin_model

// ### dv/tb_top.sv
// Self-checking bench for the external interrupt and timer input block.
// Assumes an AXI4-Lite master here and the pin model as the far side.
`timescale 1ns/1ps
module tb_top;
  logic core_clk, srst;
  logic [3:0] pins;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic irq_flag_ch0, irq_flag_ch1;
  logic [15:0] timer_zero_count, timer_one_count;
  int bad_count, samples_checked;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_TMR0 = 5'h08;
  localparam logic [4:0] A_TMR1 = 5'h0C;
  localparam logic [4:0] A_HOLE = 5'h10;

  // Wider address bus than the default so an unmapped place exists
  tei_top #(.ADDR_W(5)) i_tei_top (
    .core_clk(core_clk), .srst(srst),
    .ext_irq_pin_ch0(pins[0]), .ext_irq_pin_ch1(pins[1]),
    .timer_zero_count_pin(pins[2]), .timer_one_count_pin(pins[3]),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_flag_ch0(irq_flag_ch0), .irq_flag_ch1(irq_flag_ch1),
    .timer_zero_count(timer_zero_count), .timer_one_count(timer_one_count)
  );

  tei_pin_model i_tei_pin_model (.core_clk(core_clk), .pins(pins));

  // Free-running 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Single exit point: counts, then verdict
  task automatic close_out();
    $display("TB: checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Used-up wait bound counts as a mismatch and ends the run
  task automatic bound(inout int n);
    n++;
    if (n > 200) begin
      bad_count++;
      $display("[ERR] t=%0t wait bound hit", $time);
      close_out();
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      bound(n);
    end
    do begin
      @(posedge core_clk);
      bound(n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
  endtask

  // Read: rready held high until the answer is sampled
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      bound(n);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      bound(n);
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_rd(a, rd, rs);
    chk_resp(rs, er);
    chk_data(rd, exp);
  endtask

  // Reset values, a timer load, and the unmapped place in both directions
  task automatic sc_regs();
    rd_chk(A_CTRL, 32'h0000_0000, tei_pkg::RESP_OKAY);
    rd_chk(A_STAT, 32'h0000_000C, tei_pkg::RESP_OKAY);
    rd_chk(A_TMR0, 32'h0000_0000, tei_pkg::RESP_OKAY);
    axi_wr(A_TMR1, 32'hFFFF_1234, 4'hF, tei_pkg::RESP_OKAY);
    rd_chk(A_TMR1, 32'h0000_1234, tei_pkg::RESP_OKAY);
    axi_wr(A_HOLE, 32'hFFFF_FFFF, 4'hF, tei_pkg::RESP_SLVERR);
    rd_chk(A_HOLE, 32'h0000_0000, tei_pkg::RESP_SLVERR);
    rd_chk(A_CTRL, 32'h0000_0000, tei_pkg::RESP_OKAY);
  endtask

  // Edge mode: a short low pulse leaves a sticky flag until cleared
  task automatic sc_edge(input int ch);
    axi_wr(A_CTRL, 32'h0000_0003, 4'h1, tei_pkg::RESP_OKAY);
    i_tei_pin_model.pulse(ch, 2, 4);
    rd_chk(A_STAT, 32'h0000_000C | (32'h1 << ch), tei_pkg::RESP_OKAY);
    chk_data({31'h0, (ch == 0) ? irq_flag_ch0 : irq_flag_ch1}, 32'h0000_0001);
    axi_wr(A_STAT, 32'h1 << ch, 4'h1, tei_pkg::RESP_OKAY);
    rd_chk(A_STAT, 32'h0000_000C, tei_pkg::RESP_OKAY);
    chk_data({31'h0, (ch == 0) ? irq_flag_ch0 : irq_flag_ch1}, 32'h0000_0000);
  endtask

  // Level mode: clearing while the pin is low has no effect
  task automatic sc_level(input int ch);
    axi_wr(A_CTRL, 32'h0000_0000, 4'h1, tei_pkg::RESP_OKAY);
    i_tei_pin_model.set_pin(ch, 1'b0);
    repeat (4) @(posedge core_clk);
    axi_wr(A_STAT, 32'h1 << ch, 4'h1, tei_pkg::RESP_OKAY);
    rd_chk(A_STAT, (32'h0000_000C & ~(32'h4 << ch)) | (32'h1 << ch),
           tei_pkg::RESP_OKAY);
    i_tei_pin_model.set_pin(ch, 1'b1);
    repeat (4) @(posedge core_clk);
    axi_wr(A_STAT, 32'h1 << ch, 4'h1, tei_pkg::RESP_OKAY);
    rd_chk(A_STAT, 32'h0000_000C, tei_pkg::RESP_OKAY);
  endtask

  // Counter mode: long low pulses still count once each
  task automatic sc_count();
    axi_wr(A_CTRL, 32'h0000_0000, 4'h1, tei_pkg::RESP_OKAY);
    axi_wr(A_TMR0, 32'h0000_FFFE, 4'h3, tei_pkg::RESP_OKAY);
    axi_wr(A_TMR1, 32'h0000_0000, 4'h3, tei_pkg::RESP_OKAY);
    axi_wr(A_CTRL, 32'h0000_00F0, 4'h1, tei_pkg::RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      i_tei_pin_model.pulse(2, 5, 3);
      i_tei_pin_model.pulse(3, 1, 1);
    end
    repeat (4) @(posedge core_clk);
    chk_data({16'h0, timer_zero_count}, 32'h0000_0001);
    chk_data({16'h0, timer_one_count}, 32'h0000_0003);
    rd_chk(A_TMR1, 32'h0000_0003, tei_pkg::RESP_OKAY);
  endtask

  // Gate: a low interrupt pin halts its timer, a high one lets it run every cycle
  task automatic sc_gate();
    logic [15:0] c0, c1;
    i_tei_pin_model.set_pin(0, 1'b0);
    i_tei_pin_model.set_pin(1, 1'b0);
    axi_wr(A_CTRL, 32'h0000_003C, 4'h1, tei_pkg::RESP_OKAY);
    repeat (5) @(posedge core_clk);
    c0 = timer_zero_count;
    c1 = timer_one_count;
    repeat (10) @(posedge core_clk);
    chk_data({16'h0, timer_zero_count}, {16'h0, c0});
    chk_data({16'h0, timer_one_count}, {16'h0, c1});
    i_tei_pin_model.set_pin(0, 1'b1);
    i_tei_pin_model.set_pin(1, 1'b1);
    repeat (5) @(posedge core_clk);
    c0 = timer_zero_count;
    c1 = timer_one_count;
    repeat (10) @(posedge core_clk);
    chk_data({16'h0, timer_zero_count}, {16'h0, c0 + 16'h000A});
    chk_data({16'h0, timer_one_count}, {16'h0, c1 + 16'h000A});
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn
  initial begin
    bad_count = 0;
    samples_checked = 0;
    srst = 1'b1;
    s_axi_awaddr = 5'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 5'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    sc_regs();
    for (int ch = 0; ch < 2; ch++) begin
      sc_edge(ch);
      sc_level(ch);
    end
    sc_count();
    sc_gate();
    close_out();
  end
endmodule // tb_top
